// >>> atpc_top.sv
// Acquisition sequencer, channel-gain queue and three-counter timer block.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: About mode with a loaded count samples before and after the trigger.
// RULE2: No about, pre or post sequence runs until start is written as one.
// RULE3: About mode stops after the post-trigger count or on transfer stop.
// RULE4: The post-trigger sample count is 16 bits, so at most 64K samples.
// RULE5: Software sets about mode and a count of one for pre-trigger.
// RULE6: Pre-trigger mode stops at the trigger event or on transfer stop.
// RULE7: Post mode with a loaded count starts at start, counts up to 64K.
// RULE8: Post mode stops after the programmed count or on transfer stop.
// RULE9: The channel-gain queue holds up to 255 channel and gain entries.
// RULE10: Queue entries are used first to last, then wrap to the first.
// RULE11: Counter 1 output clocks counter 2; its output paces conversions.
// RULE12: Pacer base is 4 MHz; fastest base over 4, slowest over 65536 twice.
// RULE13: Counter 0 serves users only, with its own clock and gate pins.
// RULE14: Offsets 0x0, 0x4, 0x8 hold counter data, 0xc the control byte.
// RULE15: Software writes a counter's control byte before using its data.
// RULE16: Control bits 7 and 6 select counter 0, 1 or 2; code 11 is illegal.
// RULE17: Bits 5 and 4: latch, low byte, high byte, or low then high byte.
// RULE18: Bits 3 to 1 pick modes 0 to 5; top bit ignored for modes 2, 3.
// RULE19: Bit 0 picks 16-bit binary or four-digit decimal counting.
// RULE20: Each counter offers the six documented operating modes; counters 1 and 2 get no gate edge, so modes 1 and 5 never start there.
// RULE21: Three independent programmable counters, each 16 bits wide.
// RULE22: Counter 1 rate is base over divisor 1, pacer over both divisors.
// RULE23: A control byte with the illegal select code changes nothing.
// RULE24: About and post modes count completed samples; terminal ends it.
module atpc_top #(
	parameter int CH_W = 6,
	parameter int GN_W = 4
) (
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	input  wire logic            ce,
	input  wire logic [3:0]      io_addr,
	input  wire logic            io_wr,
	input  wire logic            io_rd,
	input  wire logic [7:0]      io_wdata,
	output logic      [7:0]      io_rdata,
	input  wire logic            cnt0_clk_in,
	input  wire logic            cnt0_gate_in,
	output logic                 cnt0_out,
	output logic                 cnt1_out,
	output logic                 cnt2_out,
	input  wire logic            about_mode_bit,
	input  wire logic            post_mode_bit,
	input  wire logic            acq_start,
	input  wire logic [15:0]     sample_count,
	input  wire logic            transfer_stop,
	input  wire logic            ext_digital_trigger_in,
	input  wire logic            sample_done,
	input  wire logic            queue_clear,
	input  wire logic            queue_wr,
	input  wire logic [CH_W-1:0] queue_chan,
	input  wire logic [GN_W-1:0] queue_gain,
	output logic      [7:0]      queue_len,
	output logic                 conv_start,
	output logic      [CH_W-1:0] conv_chan,
	output logic      [GN_W-1:0] conv_gain,
	output logic                 acq_busy,
	output logic                 acq_triggered,
	output logic                 acq_done,
	output logic      [15:0]     samples_left
);
	// Programming state of one counter as seen from the I/O side.
	typedef struct packed {
		logic [2:0]  mode;
		logic        bcd;
		logic [1:0]  acc;
		logic        wr_hi;
		logic        rd_hi;
		logic        latched;
		logic [15:0] lat;
		logic [7:0]  lo_byte;
		logic [15:0] init;
	} atpc_chan_t;

	typedef struct packed {
		atpc_chan_t [2:0]    ch;
		logic [2:0]          load;
		logic [2:0]          cwr;
		logic [2:0]          trg_s;
		logic [2:0]          clk_s;
		logic [2:0]          gate_s;
		logic [4:0]          div;
		logic                base_tick;
		logic                c1_d;
		logic                c2_d;
		atpc_pkg::atpc_acq_t acq;
		logic [15:0]         left;
		logic                trig_seen;
		logic                done;
		logic [7:0]          rdata;
		logic                conv;
		logic [CH_W-1:0]     chan;
		logic [GN_W-1:0]     gain;
		logic [7:0]          qlen;
		logic [7:0]          qptr;
	} atpc_state_t;

	atpc_state_t r;
	atpc_state_t next_r;

	// Queue storage sits beside the state record to keep it a memory.
	logic [CH_W+GN_W-1:0] qmem [256];

	logic [2:0][15:0] core_cnt;
	logic [2:0]       core_out;
	logic [2:0]       core_tick;
	logic [2:0]       core_gate;
	logic [2:0]       core_rise;
	logic             trg_rise;
	logic             pacer_rise;
	logic             addr_ok;
	logic [1:0]       idx;
	logic [15:0]      rd_val;
	logic [1:0]       sel;
	logic [2:0]       new_mode;
	logic [7:0]       qptr_inc;

	// Edges are taken from the second and third stages only, so the
	// first stage of each synchroniser feeds nothing but the second.
	assign trg_rise   = r.trg_s[1] && !r.trg_s[2];
	assign pacer_rise = core_out[2] && !r.c2_d; // RULE11

	// Counter 0 runs from its pin, counter 1 from the base clock and
	// counter 2 from counter 1, which cascades the pacer.
	assign core_tick[0] = r.clk_s[1] && !r.clk_s[2]; // RULE13
	assign core_tick[1] = r.base_tick; // RULE12
	assign core_tick[2] = core_out[1] && !r.c1_d; // RULE22
	assign core_gate[0] = r.gate_s[1];
	assign core_rise[0] = r.gate_s[1] && !r.gate_s[2];
	assign core_gate[2:1] = 2'b11;
	assign core_rise[2:1] = 2'b00;

	// Data ports decode on word offsets 0x0, 0x4 and 0x8 only.
	assign idx     = io_addr[3:2];
	assign addr_ok = (io_addr == atpc_pkg::ADDR_CNT0) ||
		(io_addr == atpc_pkg::ADDR_CNT1) ||
		(io_addr == atpc_pkg::ADDR_CNT2); // RULE14
	assign rd_val  = r.ch[idx].latched ? r.ch[idx].lat : core_cnt[idx];
	assign sel     = io_wdata[atpc_pkg::SEL_POS +: 2]; // RULE16

	// Modes 2 and 3 ignore the top mode bit, so fold it away here.
	assign new_mode = io_wdata[atpc_pkg::MODE_POS + 1] ?
		{1'b0, io_wdata[atpc_pkg::MODE_POS +: 2]} :
		io_wdata[atpc_pkg::MODE_POS +: 3]; // RULE18
	assign qptr_inc = r.qptr + 8'h01;

	// Three identical counters with different clocks; only counter 0 has a gate pin.
	for (genvar g = 0; g < 3; g++)
	begin : g_core
		atpc_counter_core u_core (
			.clk_sys   (clk_sys),
			.resetn    (resetn),
			.ce        (ce),
			.tick      (core_tick[g]),
			.gate      (core_gate[g]),
			.gate_rise (core_rise[g]),
			.ctrl_wr   (r.cwr[g]),
			.mode      (r.ch[g].mode),
			.bcd       (r.ch[g].bcd),
			.load      (r.load[g]),
			.init      (r.ch[g].init),
			.count     (core_cnt[g]),
			.out       (core_out[g])
		); // RULE21
	end

	// Next-state logic for the I/O protocol, pins and the sequencer.
	always_comb
	begin
		next_r           = r;
		next_r.load      = 3'b000;
		next_r.cwr       = 3'b000;
		next_r.done      = 1'b0;
		next_r.conv      = 1'b0;
		next_r.trg_s     = {r.trg_s[1:0], ext_digital_trigger_in};
		next_r.clk_s     = {r.clk_s[1:0], cnt0_clk_in};
		next_r.gate_s    = {r.gate_s[1:0], cnt0_gate_in};
		next_r.c1_d      = core_out[1];
		next_r.c2_d      = core_out[2];
		next_r.base_tick = (r.div == atpc_pkg::BASE_DIV_LAST);
		if (r.div == atpc_pkg::BASE_DIV_LAST)
			next_r.div = 5'h00;
		else
			next_r.div = r.div + 5'h01;

		// Control byte: latch command or a new setup for one counter.
		if (io_wr && io_addr == atpc_pkg::ADDR_CTRL &&
			sel != atpc_pkg::SEL_ILLEGAL) // RULE23
		begin
			if (io_wdata[atpc_pkg::ACC_POS +: 2] == atpc_pkg::ACC_LATCH)
			begin
				if (!r.ch[sel].latched)
				begin
					next_r.ch[sel].lat     = core_cnt[sel];
					next_r.ch[sel].latched = 1'b1;
					next_r.ch[sel].rd_hi   = 1'b0;
				end // RULE17
			end
			else
			begin
				next_r.ch[sel].acc     = io_wdata[atpc_pkg::ACC_POS +: 2];
				next_r.ch[sel].mode    = new_mode;
				next_r.ch[sel].bcd     = io_wdata[atpc_pkg::BCD_POS];
				next_r.ch[sel].wr_hi   = 1'b0;
				next_r.ch[sel].rd_hi   = 1'b0;
				next_r.ch[sel].latched = 1'b0;
				next_r.cwr[sel]        = 1'b1; // RULE15
			end
		end

		// Data port writes load the count in the programmed byte order.
		if (io_wr && addr_ok)
		begin
			if (r.ch[idx].acc == atpc_pkg::ACC_LSB)
			begin
				next_r.ch[idx].init = {8'h00, io_wdata};
				next_r.load[idx]    = 1'b1;
			end
			else if (r.ch[idx].acc == atpc_pkg::ACC_MSB)
			begin
				next_r.ch[idx].init = {io_wdata, 8'h00};
				next_r.load[idx]    = 1'b1;
			end
			else if (!r.ch[idx].wr_hi)
			begin
				next_r.ch[idx].lo_byte = io_wdata;
				next_r.ch[idx].wr_hi   = 1'b1;
			end
			else
			begin
				next_r.ch[idx].init  = {io_wdata, r.ch[idx].lo_byte};
				next_r.ch[idx].wr_hi = 1'b0;
				next_r.load[idx]     = 1'b1;
			end // RULE17
		end

		// Data port reads; a latched value is released once fully read.
		if (io_rd && addr_ok)
		begin
			if (r.ch[idx].acc == atpc_pkg::ACC_LSB)
			begin
				next_r.rdata           = rd_val[7:0];
				next_r.ch[idx].latched = 1'b0;
			end
			else if (r.ch[idx].acc == atpc_pkg::ACC_MSB)
			begin
				next_r.rdata           = rd_val[15:8];
				next_r.ch[idx].latched = 1'b0;
			end
			else if (!r.ch[idx].rd_hi)
			begin
				next_r.rdata         = rd_val[7:0];
				next_r.ch[idx].rd_hi = 1'b1;
			end
			else
			begin
				next_r.rdata           = rd_val[15:8];
				next_r.ch[idx].rd_hi   = 1'b0;
				next_r.ch[idx].latched = 1'b0;
			end // RULE17
		end
		else if (io_rd)
			next_r.rdata = atpc_pkg::BYTE_RESET;

		// Queue fill and clear; writes beyond the depth are dropped.
		if (queue_clear)
			next_r.qlen = 8'h00;
		else if (queue_wr && r.qlen != atpc_pkg::QUEUE_MAX)
			next_r.qlen = r.qlen + 8'h01; // RULE9

		// Each pacer edge during an acquisition starts one conversion
		// on the current queue entry and steps the queue with wrap.
		if (r.acq != atpc_pkg::ATPC_IDLE && pacer_rise)
		begin
			next_r.conv = 1'b1;
			next_r.chan = qmem[r.qptr][CH_W+GN_W-1:GN_W];
			next_r.gain = qmem[r.qptr][GN_W-1:0];
			if (qptr_inc >= r.qlen)
				next_r.qptr = 8'h00;
			else
				next_r.qptr = qptr_inc; // RULE10
		end

		// Acquisition sequencer; transfer stop ends any running mode.
		unique case (r.acq)
		atpc_pkg::ATPC_IDLE:
			if (acq_start) // RULE2
			begin
				next_r.left      = sample_count; // RULE4
				next_r.qptr      = 8'h00;
				next_r.trig_seen = 1'b0;
				if (about_mode_bit)
					next_r.acq = atpc_pkg::ATPC_WAIT; // RULE1
				else if (post_mode_bit)
					next_r.acq = atpc_pkg::ATPC_CNT; // RULE7
				else
					next_r.acq = atpc_pkg::ATPC_FREE;
			end
		atpc_pkg::ATPC_WAIT:
			if (transfer_stop)
			begin
				next_r.acq  = atpc_pkg::ATPC_IDLE;
				next_r.done = 1'b1;
			end
			else if (trg_rise)
			begin
				next_r.trig_seen = 1'b1;
				if (r.left == atpc_pkg::SAMPLE_LAST)
				begin
					next_r.acq  = atpc_pkg::ATPC_IDLE;
					next_r.done = 1'b1; // RULE6
				end
				else
					next_r.acq = atpc_pkg::ATPC_CNT; // RULE5
			end
		atpc_pkg::ATPC_CNT:
			if (transfer_stop)
			begin
				next_r.acq  = atpc_pkg::ATPC_IDLE;
				next_r.done = 1'b1; // RULE3
			end
			else if (sample_done)
			begin
				if (r.left == atpc_pkg::SAMPLE_LAST)
				begin
					next_r.acq  = atpc_pkg::ATPC_IDLE;
					next_r.done = 1'b1; // RULE8
				end
				else
					next_r.left = r.left - 16'h0001; // RULE24
			end
		atpc_pkg::ATPC_FREE:
			if (transfer_stop)
			begin
				next_r.acq  = atpc_pkg::ATPC_IDLE;
				next_r.done = 1'b1;
			end
		endcase
	end

	// State register with synchronous active-low reset and clock enable.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			r <= '0;
			for (int i = 0; i < 3; i++)
			begin
				r.ch[i].acc  <= atpc_pkg::ACC_RESET;
				r.ch[i].mode <= atpc_pkg::MODE_RESET;
				r.ch[i].init <= atpc_pkg::CNT_RESET;
			end
			r.acq <= atpc_pkg::ATPC_IDLE;
		end
		else if (ce)
			r <= next_r;
	end

	// Queue memory write; a clear in the same cycle takes precedence.
	always_ff @(posedge clk_sys)
	begin
		if (ce && !queue_clear && queue_wr && r.qlen != atpc_pkg::QUEUE_MAX)
			qmem[r.qlen] <= {queue_chan, queue_gain}; // RULE9
	end

	assign io_rdata      = r.rdata;
	assign cnt0_out      = core_out[0];
	assign cnt1_out      = core_out[1];
	assign cnt2_out      = core_out[2];
	assign queue_len     = r.qlen;
	assign conv_start    = r.conv;
	assign conv_chan     = r.chan;
	assign conv_gain     = r.gain;
	assign acq_busy      = (r.acq != atpc_pkg::ATPC_IDLE);
	assign acq_triggered = r.trig_seen;
	assign acq_done      = r.done;
	assign samples_left  = r.left;
endmodule
`default_nettype wire

// >>> atpc_pkg.sv
// Package with the constants and types of the acquisition pacer counter.
`default_nettype none
package atpc_pkg;

	// Port offsets of the counter block on the I/O map.
	localparam logic [3:0] ADDR_CNT0 = 4'h0;
	localparam logic [3:0] ADDR_CNT1 = 4'h4;
	localparam logic [3:0] ADDR_CNT2 = 4'h8;
	localparam logic [3:0] ADDR_CTRL = 4'hc;

	// Field positions inside the control byte.
	localparam int SEL_POS  = 6;
	localparam int ACC_POS  = 4;
	localparam int MODE_POS = 1;
	localparam int BCD_POS  = 0;

	// Counter select and access codes.
	localparam logic [1:0] SEL_ILLEGAL = 2'h3;
	localparam logic [1:0] ACC_LATCH   = 2'h0;
	localparam logic [1:0] ACC_LSB     = 2'h1;
	localparam logic [1:0] ACC_MSB     = 2'h2;
	localparam logic [1:0] ACC_LOHI    = 2'h3;

	// Operating modes after folding the ignored top bit of modes 2 and 3.
	localparam logic [2:0] MODE0 = 3'h0;
	localparam logic [2:0] MODE1 = 3'h1;
	localparam logic [2:0] MODE2 = 3'h2;
	localparam logic [2:0] MODE3 = 3'h3;
	localparam logic [2:0] MODE4 = 3'h4;
	localparam logic [2:0] MODE5 = 3'h5;

	// Values after reset.
	localparam logic [1:0]  ACC_RESET  = ACC_LOHI;
	localparam logic [2:0]  MODE_RESET = MODE0;
	localparam logic [15:0] CNT_RESET  = 16'h0000;
	localparam logic [7:0]  BYTE_RESET = 8'h00;

	// The base clock of counter 1 is cut from the system clock.
	localparam int CLK_HZ   = 100_000_000;
	localparam int BASE_HZ  = 4_000_000;
	localparam int BASE_DIV = CLK_HZ / BASE_HZ;
	localparam logic [4:0] BASE_DIV_LAST = 5'(BASE_DIV - 1);

	// Channel-gain queue depth and sample counter terminal value.
	localparam logic [7:0]  QUEUE_MAX   = 8'hff;
	localparam logic [15:0] SAMPLE_LAST = 16'h0001;

	// Acquisition sequencer states.
	typedef enum logic [1:0] {
		ATPC_IDLE = 2'b00,
		ATPC_WAIT = 2'b01,
		ATPC_CNT  = 2'b10,
		ATPC_FREE = 2'b11
	} atpc_acq_t;

endpackage
`default_nettype wire

// >>> atpc_counter_core.sv
// One 16-bit programmable down counter with six operating modes.
`timescale 1ns/1ps
`default_nettype none
module atpc_counter_core (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        tick,
	input  wire logic        gate,
	input  wire logic        gate_rise,
	input  wire logic        ctrl_wr,
	input  wire logic [2:0]  mode,
	input  wire logic        bcd,
	input  wire logic        load,
	input  wire logic [15:0] init,
	output logic      [15:0] count,
	output logic             out
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        out;
		logic        pend;
		logic        trig;
		logic        run;
	} atpc_core_t;

	atpc_core_t r;
	atpc_core_t next_r;
	logic [15:0] dec;
	logic [15:0] half;

	// Decrement in binary or four-digit decimal; zero wraps to the top.
	function automatic logic [15:0] atpc_dec(input logic [15:0] v,
		input logic b);
		logic [15:0] d;
		logic        br;
		d  = v;
		br = 1'b1;
		if (!b)
			d = v - 16'h0001;
		else
			for (int i = 0; i < 4; i++)
			begin
				if (br && d[i*4 +: 4] == 4'h0)
					d[i*4 +: 4] = 4'h9;
				else if (br)
				begin
					d[i*4 +: 4] = d[i*4 +: 4] - 4'h1;
					br = 1'b0;
				end
			end
		return d;
	endfunction

	// A loaded zero means the full range, so its half is the top bit.
	assign dec  = atpc_dec(r.cnt, bcd); // RULE19
	assign half = (init == 16'h0000) ? 16'h8000 : (init >> 1);

	// Mode behaviour; counting happens only on the tick of this counter.
	always_comb
	begin
		next_r = r;
		if (ctrl_wr)
		begin
			next_r.out  = (mode != atpc_pkg::MODE0);
			next_r.run  = 1'b0;
			next_r.pend = 1'b0;
			next_r.trig = 1'b0;
		end
		else
		begin
			if (load)
			begin
				next_r.pend = 1'b1;
				if (mode == atpc_pkg::MODE0)
					next_r.out = 1'b0;
			end
			if (tick)
			begin
				unique case (mode) // RULE20
				atpc_pkg::MODE0, atpc_pkg::MODE4:
					if (r.pend)
					begin
						next_r.cnt  = init;
						next_r.run  = 1'b1;
						next_r.pend = 1'b0;
					end
					else if (r.run && gate)
					begin
						next_r.cnt = dec;
						if (dec == 16'h0000)
						begin
							next_r.out = (mode == atpc_pkg::MODE0);
							next_r.run = (mode == atpc_pkg::MODE0);
						end
					end
					else if (!r.out && mode == atpc_pkg::MODE4)
						next_r.out = 1'b1;
				atpc_pkg::MODE1, atpc_pkg::MODE5:
					if (r.trig && r.pend)
					begin
						next_r.cnt  = init;
						next_r.run  = 1'b1;
						next_r.trig = 1'b0;
						next_r.out  = (mode == atpc_pkg::MODE5);
					end
					else if (r.run)
					begin
						next_r.cnt = dec;
						if (dec == 16'h0000)
						begin
							next_r.out = (mode == atpc_pkg::MODE1);
							next_r.run = 1'b0;
						end
					end
					else if (!r.out)
						next_r.out = 1'b1;
				atpc_pkg::MODE2, atpc_pkg::MODE3:
					if (!gate)
						next_r.out = 1'b1;
					else if (r.pend || r.trig || (r.run && r.cnt == 16'h0001))
					begin
						next_r.cnt  = init;
						next_r.run  = 1'b1;
						next_r.pend = 1'b0;
						next_r.trig = 1'b0;
						next_r.out  = 1'b1;
					end
					else if (r.run)
					begin
						next_r.cnt = dec;
						if (mode == atpc_pkg::MODE2)
							next_r.out = (dec != 16'h0001);
						else
							next_r.out = (dec > half);
					end
				default:
					next_r.run = 1'b0;
				endcase
			end
			// A gate edge in the tick that consumes the last one still
			// counts, so the set is applied after the mode logic.
			if (gate_rise)
				next_r.trig = 1'b1;
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			r <= '0;
		else if (ce)
			r <= next_r;
	end

	assign count = r.cnt;
	assign out   = r.out;
endmodule
`default_nettype wire

// >>> atpc_checker.sv
// Checker of the acquisition and register port behaviour of atpc_top.
`timescale 1ns/1ps
`default_nettype none
module atpc_checker (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic [3:0]  io_addr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata,
	input wire logic        acq_start,
	input wire logic        about_mode_bit,
	input wire logic        post_mode_bit,
	input wire logic        transfer_stop,
	input wire logic        sample_done,
	input wire logic        acq_busy,
	input wire logic        acq_done,
	input wire logic [15:0] samples_left,
	input wire logic        queue_clear,
	input wire logic        queue_wr,
	input wire logic [7:0]  queue_len,
	input wire logic        conv_start
);
	logic post_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// Post mode is visible only at start, so it is remembered here.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			post_q <= 1'b0;
		else if (ce && acq_start && !acq_busy)
			post_q <= post_mode_bit && !about_mode_bit;
	end

	// An ending drops busy and pulses done for exactly one cycle.
	sequence s_end;
		!acq_busy && acq_done ##1 !acq_done;
	endsequence

	// One counted sample of a post-mode run that is not being stopped.
	sequence s_post_smp;
		post_q && acq_busy && ce && sample_done && !transfer_stop;
	endsequence

	a_start_busy: assert property (ce && acq_start && !acq_busy
		&& !transfer_stop |=> acq_busy) else $error("Start was ignored.");
	a_busy_cause: assert property ($rose(acq_busy)
		|-> $past(acq_start)) else $error("Busy rose without start.");
	a_stop_ends: assert property (ce && acq_busy && transfer_stop
		|=> s_end) else $error("Stop did not end the run.");
	a_post_last: assert property (s_post_smp
		##0 samples_left == 16'h0001 |=> s_end) else $error("Run overran.");
	a_post_dec: assert property (s_post_smp
		##0 samples_left > 16'h0001 |=> acq_busy
		&& samples_left == $past(samples_left) - 16'h0001)
		else $error("Sample count did not step down.");
	a_idle_conv: assert property (!acq_busy && !$past(acq_busy)
		|-> !conv_start) else $error("Conversion while idle.");
	a_rd_zero: assert property (ce && io_rd && (io_addr == 4'hc
		|| io_addr[1:0] != 2'h0) |=> io_rdata == 8'h00)
		else $error("Control or hole read was nonzero.");
	a_q_clear: assert property (ce && queue_clear
		|=> queue_len == 8'h00) else $error("Queue not emptied.");
	a_q_grow: assert property (ce && queue_wr && !queue_clear
		&& queue_len != 8'hff |=> queue_len == $past(queue_len) + 8'h01)
		else $error("Queue length did not grow.");
endmodule
`default_nettype wire

// >>> atpc_sample_source.sv
// Converter model that answers each conversion start with one sample.
`timescale 1ns/1ps
`default_nettype none
module atpc_sample_source (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic conv_start,
	input  wire logic slow,
	output logic      sample_done
);
	logic [5:0] dly;

	// A slow converter lags the pacer, so samples fall mid-window.
	always @(posedge clk_sys)
	begin
		if (!resetn)
			dly <= 6'h00;
		else
			dly <= {dly[4:0], conv_start};
	end
	assign sample_done = slow ? dly[5] : dly[0];
endmodule
`default_nettype wire

// >>> atpc_top_tb.sv
// Self-checking bench of the acquisition pacer counter block.
`timescale 1ns/1ps
`default_nettype none
module atpc_top_tb;
	logic        clk_sys, resetn, ce, io_wr, io_rd, rd_q, slow;
	logic        cnt0_clk_in, cnt0_gate_in, cnt0_out, cnt1_out, cnt2_out;
	logic        about_mode_bit, post_mode_bit, acq_start, transfer_stop;
	logic        ext_digital_trigger_in, sample_done, queue_clear, queue_wr;
	logic        conv_start, acq_busy, acq_triggered, acq_done;
	logic [3:0]  io_addr, queue_gain, conv_gain;
	logic [7:0]  io_wdata, io_rdata, queue_len;
	logic [5:0]  queue_chan, conv_chan;
	logic [15:0] sample_count, samples_left;
	logic [9:0]  ent [3];
	logic [7:0]  rdq [$];
	logic [9:0]  cvq [$];
	int          err_total, num_checks, cyc, nsamp, t1, seed;

	atpc_top uut (.clk_sys, .resetn, .ce, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .cnt0_clk_in, .cnt0_gate_in, .cnt0_out,
		.cnt1_out, .cnt2_out, .about_mode_bit, .post_mode_bit, .acq_start,
		.sample_count, .transfer_stop, .ext_digital_trigger_in, .sample_done,
		.queue_clear, .queue_wr, .queue_chan, .queue_gain, .queue_len,
		.conv_start, .conv_chan, .conv_gain, .acq_busy, .acq_triggered,
		.acq_done, .samples_left);
	atpc_sample_source src (.clk_sys, .resetn, .conv_start, .slow,
		.sample_done);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bus tasks hold each strobe for one whole cycle, as one access.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		@(negedge clk_sys);
		io_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		{io_addr, io_rd} = {a, 1'b1};
		rdq.push_back(e);
		@(negedge clk_sys);
		io_rd = 1'b0;
	endtask

	// The pin is synchronised, so each level is held for several cycles.
	task automatic tick0();
		cnt0_clk_in = 1'b1;
		repeat (4) @(negedge clk_sys);
		cnt0_clk_in = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask

	function automatic logic ev(input int k);
		return k == 0 ? conv_start : k == 1 ? acq_done : sample_done;
	endfunction

	// Waits for a pulse under a bound; a stuck design counts as a mismatch.
	task automatic wait_ev(input int k);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (ev(k) !== 1'b1 && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 3000)
			chk(16'h0, 16'h1);
	endtask

	task automatic start(input logic am, pm, input logic [15:0] n);
		{about_mode_bit, post_mode_bit, sample_count} = {am, pm, n};
		acq_start = 1'b1;
		@(negedge clk_sys);
		acq_start = 1'b0;
		nsamp = 0;
	endtask

	task automatic stop_run();
		transfer_stop = 1'b1;
		@(negedge clk_sys);
		transfer_stop = 1'b0;
		chk(acq_busy, 16'h0);
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Counts cycles and samples, and compares results with the oldest note.
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (sample_done === 1'b1)
			nsamp <= nsamp + 1;
		if (rd_q && rdq.size() > 0)
			chk(io_rdata, rdq.pop_front());
		if (conv_start === 1'b1 && cvq.size() > 0)
			chk({conv_chan, conv_gain}, cvq.pop_front());
		rd_q <= io_rd;
		if (cyc == 20000)
		begin
			err_total++;
			finish_test();
		end
	end

	initial
	begin
		{resetn, io_wr, io_rd, cnt0_clk_in, cnt0_gate_in, acq_start} = '0;
		{about_mode_bit, post_mode_bit, transfer_stop, slow, rd_q} = '0;
		{ext_digital_trigger_in, queue_clear, queue_wr, io_addr} = '0;
		{io_wdata, sample_count, queue_chan, queue_gain} = '0;
		{cyc, nsamp, err_total, num_checks} = '0;
		ce = 1'b1;
		seed = 32'h49aa;
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		rd(4'hc, 8'h00);
		rd(4'h2, 8'h00);
		// Every mode code, folded top bit too, sets its idle output level.
		for (int m = 0; m < 8; m++)
		begin
			wr(4'hc, {4'h3, 3'(m), 1'b0});
			repeat (2) @(negedge clk_sys);
			chk(cnt0_out, m == 0 ? 16'h0 : 16'h1);
		end
		// Gate stays low, so counter 0 holds still and reads are exact.
		wr(4'hc, 8'h30);
		wr(4'h0, 8'h34);
		wr(4'h0, 8'h12);
		tick0();
		chk(cnt0_out, 16'h0);
		wr(4'hc, 8'h00);
		rd(4'h0, 8'h34);
		rd(4'h0, 8'h12);
		wr(4'hc, 8'h10);
		wr(4'h0, 8'h56);
		tick0();
		rd(4'h0, 8'h56);
		wr(4'hc, 8'h20);
		wr(4'h0, 8'h9a);
		tick0();
		rd(4'h0, 8'h9a);
		wr(4'hc, 8'hd0);
		rd(4'h0, 8'h9a);
		// A decimal count steps from 1000 to 0999 in one gated tick.
		wr(4'hc, 8'h31);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h10);
		cnt0_gate_in = 1'b1;
		tick0();
		tick0();
		cnt0_gate_in = 1'b0;
		wr(4'hc, 8'h00);
		rd(4'h0, 8'h99);
		rd(4'h0, 8'h09);
		// Pacer of divisors 4 and 2 gives one conversion per 200 cycles.
		wr(4'hc, 8'h74);
		wr(4'h4, 8'h04);
		wr(4'h4, 8'h00);
		wr(4'hc, 8'hb4);
		wr(4'h8, 8'h02);
		wr(4'h8, 8'h00);
		queue_clear = 1'b1;
		@(negedge clk_sys);
		queue_clear = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			ent[i] = 10'($random(seed));
			{queue_chan, queue_gain, queue_wr} = {ent[i], 1'b1};
			@(negedge clk_sys);
			cvq.push_back(ent[i]);
		end
		queue_wr = 1'b0;
		cvq.push_back(ent[0]);
		@(negedge clk_sys);
		chk(queue_len, 16'h3);
		start(1'b0, 1'b0, 16'h0);
		wait_ev(0);
		t1 = cyc;
		chk({cnt1_out, cnt2_out}, 16'h3);
		wait_ev(0);
		chk(16'(cyc - t1), 16'h00c8);
		repeat (2) wait_ev(0);
		@(negedge clk_sys);
		chk(16'(cvq.size()), 16'h0);
		stop_run();
		// Post mode counts from start; a second run is cut short.
		start(1'b0, 1'b1, 16'h3);
		wait_ev(2);
		@(negedge clk_sys);
		chk(samples_left, 16'h2);
		wait_ev(1);
		chk(16'(nsamp), 16'h3);
		start(1'b0, 1'b1, 16'h64);
		wait_ev(2);
		stop_run();
		// About mode: early samples are not counted until the trigger.
		slow = 1'b1;
		start(1'b1, 1'b0, 16'h2);
		wait_ev(2);
		ext_digital_trigger_in = 1'b1;
		// The pre-trigger sample is still counted at the next edge.
		@(negedge clk_sys);
		nsamp = 0;
		wait_ev(1);
		chk(16'(nsamp), 16'h2);
		chk(acq_triggered, 16'h1);
		ext_digital_trigger_in = 1'b0;
		start(1'b1, 1'b0, 16'h1);
		wait_ev(2);
		ext_digital_trigger_in = 1'b1;
		@(negedge clk_sys);
		nsamp = 0;
		repeat (8) @(negedge clk_sys);
		chk({acq_busy, 15'(nsamp)}, 16'h0);
		ext_digital_trigger_in = 1'b0;
		// Idle without a start: no conversion, so no sample arrives.
		repeat (400) @(negedge clk_sys);
		chk({acq_busy, 15'(nsamp)}, 16'h0);
		finish_test();
	end
endmodule

bind atpc_top atpc_checker chk_i (.clk_sys, .resetn, .ce, .io_addr, .io_rd,
	.io_rdata, .acq_start, .about_mode_bit, .post_mode_bit, .transfer_stop,
	.sample_done, .acq_busy, .acq_done, .samples_left, .queue_clear,
	.queue_wr, .queue_len, .conv_start);
`default_nettype wire
